// ### pkg/ixf_params.svh
`ifndef IXF_PARAMS_SVH
`define IXF_PARAMS_SVH

`define IXF_CHAR_W 8
`define IXF_TX_FIFO_DEPTH 8
`define IXF_CHAR_RST 8'h00
`define IXF_STAT_ERROR 8'h01
`define IXF_STAT_STOP 8'h02
`define IXF_STAT_RESUME 8'h04

`endif

// ### pkg/ixf_pkg.sv
package ixf_pkg;

    typedef struct packed {
        logic rxEnabled;
        logic txEnabled;
        logic rxStopSent;
        logic rxResumeSent;
        logic txStopReceived;
        logic txResumeReceived;
    } ixf_status_t;

    typedef struct packed {
        logic isStatus;
        logic [7:0] data;
    } ixf_rx_word_t;

    typedef enum logic [1:0] {HOLD_DATA, HOLD_RESUME, HOLD_STOP} ixf_hold_kind_t;

    typedef enum logic {RX_IDLE, RX_SECOND} ixf_rx_state_t;

endpackage

// ### src/ixf_flow_ctrl.sv
`timescale 1ns/10ps
`include "ixf_params.svh"

// ****************************************
// Transmit FIFO
// ****************************************
module ixf_fifo #(
    parameter int WIDTH = `IXF_CHAR_W,
    parameter int DEPTH = `IXF_TX_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_check
        $error("ixf_fifo DEPTH must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
    logic [AW:0] count, next_count;
    logic next_inReady, next_outValid, push, pop;

    always_comb begin
        push = inValid & inReady;
        pop = outValid & outReady;
        next_wrPtr = push ? wrPtr + 1'b1 : wrPtr;
        next_rdPtr = pop ? rdPtr + 1'b1 : rdPtr;
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
        // Flags come from flops so the ready seen by the source is glitch free
        next_inReady = (next_count != (AW+1)'(DEPTH));
        next_outValid = (next_count != '0);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
            inReady <= 1'b0;
            outValid <= 1'b0;
        end else begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            count <= next_count;
            inReady <= next_inReady;
            outValid <= next_outValid;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end

    assign outData = mem[rdPtr];
endmodule

// ****************************************
// In-band flow control channel
// ****************************************
module ixf_flow_ctrl #(
    parameter int TX_FIFO_DEPTH = `IXF_TX_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] resumeCharReg,
    input wire logic [7:0] stopCharReg,
    input wire logic specialCharDetectEnable,
    input wire logic autoTxInbandEnable,
    input wire logic errorCharMatchEnable,
    input wire logic impliedResumeMode,
    input wire logic flowCharTransparency,
    input wire logic cmdSendResume,
    input wire logic cmdSendStop,
    input wire logic cmdRxEnable,
    input wire logic cmdRxDisable,
    input wire logic cmdTxEnable,
    input wire logic cmdTxDisable,
    input wire logic txInValid,
    input wire logic [7:0] txInData,
    output logic txInReady,
    output logic txOutValid,
    output logic [7:0] txOutData,
    input wire logic txOutReady,
    input wire logic rxValid,
    input wire logic [7:0] rxChar,
    input wire logic rxError,
    output logic rxFifoWrite,
    output ixf_pkg::ixf_rx_word_t rxFifoWord,
    output logic rxException,
    output ixf_pkg::ixf_status_t channelFlowStatusReg
);
    logic fifoOutValid, fifoOutReady;
    logic [7:0] fifoOutData;

    ixf_fifo #(.WIDTH(8), .DEPTH(TX_FIFO_DEPTH)) u_txFifo (
        .clk(clk),
        .rst_n(rst_n),
        .inValid(txInValid),
        .inData(txInData),
        .inReady(txInReady),
        .outValid(fifoOutValid),
        .outData(fifoOutData),
        .outReady(fifoOutReady)
    );

    // ****************************************
    // Transmit holding register and flow state
    // ****************************************
    ixf_pkg::ixf_status_t next_status;
    ixf_pkg::ixf_hold_kind_t holdKind, next_holdKind;
    logic next_txOutValid;
    logic [7:0] next_txOutData;
    logic pendResume, pendStop, next_pendResume, next_pendStop;
    logic resumeOnWire, next_resumeOnWire;
    logic holdFree, matchOk, gotStop, gotResume, restart, storeRx, flowChar;

    always_comb begin
        next_status = channelFlowStatusReg;
        next_txOutValid = txOutValid;
        next_txOutData = txOutData;
        next_holdKind = holdKind;
        next_pendResume = pendResume | cmdSendResume;
        next_pendStop = pendStop | cmdSendStop;
        next_resumeOnWire = resumeOnWire;
        fifoOutReady = 1'b0;

        matchOk = rxValid && channelFlowStatusReg.rxEnabled && specialCharDetectEnable && autoTxInbandEnable
            && (!rxError || errorCharMatchEnable);
        gotStop = matchOk && (rxChar == stopCharReg);
        gotResume = matchOk && (rxChar == resumeCharReg) && !gotStop;
        restart = channelFlowStatusReg.txStopReceived && (gotResume ||
            (impliedResumeMode && rxValid && channelFlowStatusReg.rxEnabled));

        // Received flow characters only gate loading of FIFO data into the holding register
        if (gotStop) begin
            next_status.txStopReceived = 1'b1;
            next_status.txResumeReceived = 1'b0;
        end else if (restart) begin
            next_status.txStopReceived = 1'b0;
            next_status.txResumeReceived = 1'b1;
        end

        holdFree = !txOutValid || txOutReady;
        if (txOutValid && txOutReady) begin
            next_txOutValid = 1'b0;
            if (holdKind == ixf_pkg::HOLD_RESUME) begin
                next_resumeOnWire = 1'b1;
            end
        end
        // Special characters jump the FIFO and ignore the stopped state
        if (holdFree && channelFlowStatusReg.txEnabled) begin
            if (pendStop) begin
                next_txOutValid = 1'b1;
                next_txOutData = stopCharReg;
                next_holdKind = ixf_pkg::HOLD_STOP;
                next_pendStop = cmdSendStop;
            end else if (pendResume) begin
                next_txOutValid = 1'b1;
                next_txOutData = resumeCharReg;
                next_holdKind = ixf_pkg::HOLD_RESUME;
                next_pendResume = cmdSendResume;
            end else if (fifoOutValid && !channelFlowStatusReg.txStopReceived) begin
                fifoOutReady = 1'b1;
                next_txOutValid = 1'b1;
                next_txOutData = fifoOutData;
                next_holdKind = ixf_pkg::HOLD_DATA;
                if (!restart) begin
                    next_status.txResumeReceived = 1'b0;
                end
            end
        end

        if (cmdSendStop) begin
            next_status.rxStopSent = 1'b1;
            next_status.rxResumeSent = 1'b0;
        end else if (cmdSendResume) begin
            next_status.rxStopSent = 1'b0;
            next_status.rxResumeSent = 1'b1;
            next_resumeOnWire = 1'b0;
        end else if (resumeOnWire && rxValid) begin
            next_status.rxResumeSent = 1'b0;
            next_resumeOnWire = 1'b0;
        end

        // Enable and disable beat any flag event of their own direction in the same cycle
        if (cmdRxEnable || cmdRxDisable) begin
            next_status.rxEnabled = cmdRxEnable;
            next_status.rxStopSent = 1'b0;
            next_status.rxResumeSent = 1'b0;
        end
        if (cmdTxEnable || cmdTxDisable) begin
            next_status.txEnabled = cmdTxEnable;
            next_status.txStopReceived = 1'b0;
            next_status.txResumeReceived = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            channelFlowStatusReg <= '0;
            txOutValid <= 1'b0;
            txOutData <= `IXF_CHAR_RST;
            holdKind <= ixf_pkg::HOLD_DATA;
            pendResume <= 1'b0;
            pendStop <= 1'b0;
            resumeOnWire <= 1'b0;
        end else begin
            channelFlowStatusReg <= next_status;
            txOutValid <= next_txOutValid;
            txOutData <= next_txOutData;
            holdKind <= next_holdKind;
            pendResume <= next_pendResume;
            pendStop <= next_pendStop;
            resumeOnWire <= next_resumeOnWire;
        end
    end

    // ****************************************
    // Receive path into the receive FIFO
    // ****************************************
    ixf_pkg::ixf_rx_state_t rxState, next_rxState;
    logic [7:0] rxSaved, next_rxSaved;
    logic next_rxFifoWrite, next_rxException;
    ixf_pkg::ixf_rx_word_t next_rxFifoWord;

    always_comb begin
        next_rxState = rxState;
        next_rxSaved = rxSaved;
        next_rxFifoWrite = 1'b0;
        next_rxException = 1'b0;
        next_rxFifoWord = rxFifoWord;
        flowChar = gotStop || gotResume;
        // Stop state never blocks storing, only transparency drops flow characters
        storeRx = rxValid && channelFlowStatusReg.rxEnabled && !(flowChar && flowCharTransparency);
        unique case (rxState)
            ixf_pkg::RX_IDLE: begin
                if (storeRx && (flowChar || rxError)) begin
                    next_rxFifoWrite = 1'b1;
                    next_rxException = 1'b1;
                    next_rxFifoWord.isStatus = 1'b1;
                    next_rxFifoWord.data = rxError ? `IXF_STAT_ERROR :
                        (gotStop ? `IXF_STAT_STOP : `IXF_STAT_RESUME);
                    next_rxSaved = rxChar;
                    next_rxState = ixf_pkg::RX_SECOND;
                end else if (storeRx) begin
                    next_rxFifoWrite = 1'b1;
                    next_rxFifoWord.isStatus = 1'b0;
                    next_rxFifoWord.data = rxChar;
                end
            end
            ixf_pkg::RX_SECOND: begin
                next_rxFifoWrite = 1'b1;
                next_rxFifoWord.isStatus = 1'b0;
                next_rxFifoWord.data = rxSaved;
                next_rxState = ixf_pkg::RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rxState <= ixf_pkg::RX_IDLE;
            rxSaved <= `IXF_CHAR_RST;
            rxFifoWrite <= 1'b0;
            rxException <= 1'b0;
            rxFifoWord <= '0;
        end else begin
            rxState <= next_rxState;
            rxSaved <= next_rxSaved;
            rxFifoWrite <= next_rxFifoWrite;
            rxException <= next_rxException;
            rxFifoWord <= next_rxFifoWord;
        end
    end
endmodule

// ### tb/ixf_flow_ctrl_properties.sv
`timescale 1ns/10ps
`include "ixf_params.svh"
// ********
// Flow control checks
// ********
module ixf_flow_ctrl_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rxValid,
    input wire logic rxError,
    input wire logic txOutValid,
    input wire logic txOutReady,
    input wire logic rxFifoWrite,
    input wire logic rxException,
    input wire logic specialCharDetectEnable,
    input wire logic autoTxInbandEnable,
    input wire logic flowCharTransparency,
    input wire logic cmdSendResume,
    input wire logic cmdSendStop,
    input wire logic cmdRxEnable,
    input wire logic cmdRxDisable,
    input wire logic cmdTxEnable,
    input wire logic cmdTxDisable,
    input wire logic [7:0] stopCharReg,
    input wire logic [7:0] rxChar,
    input wire logic [7:0] txOutData,
    input ixf_pkg::ixf_rx_word_t rxFifoWord,
    input ixf_pkg::ixf_status_t channelFlowStatusReg
);
    ixf_pkg::ixf_status_t st;
    logic hit;
    assign st = channelFlowStatusReg;
    // Clean stop characters only; error matching is judged by the bench
    assign hit = rxValid && !rxError && st.rxEnabled && specialCharDetectEnable && autoTxInbandEnable
        && rxChar == stopCharReg;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    stop_cmd_flag_a: assert property (cmdSendStop && !cmdSendResume && !cmdRxEnable && !cmdRxDisable
        |=> st.rxStopSent && !st.rxResumeSent) else $error("stop command flag wrong");
    resume_cmd_flag_a: assert property (cmdSendResume && !cmdSendStop && !rxValid
        && !cmdRxEnable && !cmdRxDisable |=> st.rxResumeSent && !st.rxStopSent) else $error("resume flag wrong");
    rx_flag_clear_a: assert property (cmdRxEnable || cmdRxDisable
        |=> !st.rxStopSent && !st.rxResumeSent) else $error("rx flags not cleared");
    tx_flag_clear_a: assert property (cmdTxEnable || cmdTxDisable
        |=> !st.txStopReceived && !st.txResumeReceived) else $error("tx flags not cleared");
    pair_never_set_a: assert property (!(st.rxStopSent && st.rxResumeSent)
        && !(st.txStopReceived && st.txResumeReceived)) else $error("flag pair reads 11");
    stop_exception_a: assert property (hit && !flowCharTransparency
        |=> rxFifoWrite && rxException && rxFifoWord == {1'b1, `IXF_STAT_STOP}
        ##1 rxFifoWrite && rxFifoWord == {1'b0, $past(rxChar, 2)}) else $error("exception pair wrong");
    transparent_drop_a: assert property (hit && flowCharTransparency |=> !rxFifoWrite [*2])
        else $error("transparent char stored");
    stop_halts_tx_a: assert property (hit && !cmdTxEnable && !cmdTxDisable
        |=> st.txStopReceived && !st.txResumeReceived) else $error("tx not stopped");
    holding_stands_a: assert property (txOutValid && !txOutReady
        |=> txOutValid && $stable(txOutData)) else $error("holding char dropped");
    cover property (hit ##1 rxException);
    cover property (txOutValid && txOutReady);
    cover property ($rose(st.txStopReceived));
endmodule
bind ixf_flow_ctrl ixf_flow_ctrl_properties i_props (.*);

// ### tb/ixf_remote_model.sv
`timescale 1ns/10ps
// ********
// Remote terminal
// ********
module ixf_remote_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic txOutValid,
    input wire logic [7:0] txOutData,
    output logic txOutReady,
    output logic rxValid,
    output logic rxError,
    output logic [7:0] rxChar
);
    // Raise charTime for a slow remote shifter
    int charTime = 2;
    int busy = 0;
    logic [7:0] sent[$];
    initial {txOutReady, rxValid, rxError, rxChar} = 11'h000;
    // New character only after the last one is fully shifted
    always @(posedge clk) begin
        if (rst_n && txOutValid && txOutReady) begin
            sent.push_back(txOutData);
            busy = charTime;
        end
    end
    always @(negedge clk) begin
        txOutReady = rst_n && busy == 0;
        if (busy > 0) busy--;
    end
    // Idle line shows the inverse of the last character, never stale data
    task automatic put(input logic [7:0] c, input logic e);
        @(negedge clk);
        {rxValid, rxError, rxChar} = {1'b1, e, c};
        @(negedge clk);
        {rxValid, rxError, rxChar} = {2'h0, ~c};
    endtask
endmodule

// ### tb/ixf_flow_ctrl_bench.sv
`timescale 1ns/10ps
// ********
// Flow control bench
// ********
module ixf_flow_ctrl_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic txInValid = 1'b0;
    logic [7:0] txInData = 8'h00;
    logic [4:0] cfg = 5'h00;
    logic [5:0] cmd = 6'h00;
    logic txInReady, txOutValid, txOutReady, rxValid, rxError, rxFifoWrite, rxExc;
    logic [7:0] resumeChar = 8'h11;
    logic [7:0] stopChar = 8'h13;
    logic [7:0] txOutData, rxChar;
    ixf_pkg::ixf_rx_word_t rxWord;
    ixf_pkg::ixf_status_t st;
    logic [8:0] rxLog[$];
    int n_errors = 0;
    int tests_run = 0;
    ixf_flow_ctrl i_dut (.clk(clk), .rst_n(rst_n), .resumeCharReg(resumeChar), .stopCharReg(stopChar),
        .specialCharDetectEnable(cfg[4]), .autoTxInbandEnable(cfg[3]), .errorCharMatchEnable(cfg[2]),
        .impliedResumeMode(cfg[1]), .flowCharTransparency(cfg[0]), .cmdSendResume(cmd[5]),
        .cmdSendStop(cmd[4]), .cmdRxEnable(cmd[3]), .cmdRxDisable(cmd[2]), .cmdTxEnable(cmd[1]),
        .cmdTxDisable(cmd[0]), .txInValid(txInValid), .txInData(txInData), .txInReady(txInReady),
        .txOutValid(txOutValid), .txOutData(txOutData), .txOutReady(txOutReady), .rxValid(rxValid),
        .rxChar(rxChar), .rxError(rxError), .rxFifoWrite(rxFifoWrite), .rxFifoWord(rxWord),
        .rxException(rxExc), .channelFlowStatusReg(st));
    ixf_remote_model i_remote (.*);
    initial begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rxFifoWrite === 1'b1) begin
            rxLog.push_back(rxWord);
            check(rxExc, rxWord.isStatus, "exception flag");
        end
    end
    task automatic check(input logic [8:0] got, input logic [8:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic pulse(input logic [5:0] m);
        @(negedge clk);
        cmd = m;
        @(negedge clk);
        cmd = 6'h00;
    endtask
    task automatic push(input logic [7:0] d);
        @(negedge clk);
        {txInValid, txInData} = {1'b1, d};
        // Ready is a flop, so its value at the falling edge is what the next rising edge sees
        while (txInReady !== 1'b1) @(negedge clk);
        @(negedge clk);
        txInValid = 1'b0;
    endtask
    task automatic rx(input logic [7:0] c, input logic e);
        i_remote.put(c, e);
        idle(3);
    endtask
    task automatic exp_rx(input logic [8:0] w);
        check(rxLog.size() ? rxLog.pop_front() : 'x, w, "rx word");
    endtask
    task automatic exp_tx(input logic [7:0] c);
        check(i_remote.sent.size() ? i_remote.sent.pop_front() : 'x, c, "tx char");
    endtask
    task automatic done(input string name);
        $display("test %s finished", name);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Tests need about 500 cycles; a hang is cut off well beyond that
    initial begin
        repeat (10000) @(posedge clk);
        n_errors++;
        end_of_test();
    end
    initial begin
        repeat (20) @(negedge clk);
        check(st, 6'h00, "reset status");
        rst_n = 1'b1;
        pulse(6'h0A);
        check(st, 6'h30, "enabled");
        i_remote.charTime = 20;
        push(8'hA0);
        push(8'hA1);
        push(8'hA2);
        pulse(6'h10);
        check(st, 6'h38, "stop sent");
        pulse(6'h20);
        check(st, 6'h34, "resume sent");
        idle(150);
        exp_tx(8'hA0);
        exp_tx(8'hA1);
        exp_tx(8'h13);
        exp_tx(8'h11);
        exp_tx(8'hA2);
        i_remote.charTime = 2;
        rx(8'h13, 1'b0);
        exp_rx(9'h013);
        check(st, 6'h30, "rx pair");
        done("commands");
        cfg = 5'h18;
        rx(8'h13, 1'b0);
        exp_rx(9'h102);
        exp_rx(9'h013);
        check(st, 6'h32, "tx stopped");
        push(8'hB0);
        idle(30);
        check(i_remote.sent.size(), 9'h000, "held");
        pulse(6'h20);
        idle(10);
        exp_tx(8'h11);
        rx(8'h41, 1'b0);
        exp_rx(9'h041);
        check(st, 6'h32, "still stopped");
        rx(8'h11, 1'b0);
        exp_rx(9'h104);
        exp_rx(9'h011);
        idle(10);
        exp_tx(8'hB0);
        check(st, 6'h30, "resumed");
        done("auto");
        cfg = 5'h1B;
        rx(8'h13, 1'b0);
        check(rxLog.size(), 9'h000, "discarded");
        rx(8'h42, 1'b0);
        exp_rx(9'h042);
        check(st, 6'h31, "resume pending");
        push(8'hB1);
        idle(10);
        exp_tx(8'hB1);
        check(st, 6'h30, "restarted");
        done("transparent");
        cfg = 5'h18;
        rx(8'h13, 1'b1);
        exp_rx(9'h101);
        exp_rx(9'h013);
        check(st, 6'h30, "error ignored");
        cfg = 5'h1C;
        rx(8'h13, 1'b1);
        check(st, 6'h32, "error matched");
        rxLog.delete();
        pulse(6'h01);
        check(st, 6'h20, "tx disabled");
        for (int i = 0; i < 8; i++) push(8'hC0 + 8'(i));
        idle(2);
        check(txInReady, 1'b0, "fifo full");
        i_remote.charTime = 10;
        pulse(6'h02);
        idle(120);
        for (int i = 0; i < 8; i++) exp_tx(8'hC0 + 8'(i));
        check(st, 6'h30, "tx enabled");
        done("errors and fifo");
        pulse(6'h10);
        rx(8'h66, 1'b0);
        exp_rx(9'h066);
        pulse(6'h04);
        check(st, 6'h10, "rx disabled");
        rx(8'h55, 1'b0);
        idle(20);
        check(rxLog.size(), 9'h000, "rx off");
        exp_tx(8'h13);
        done("receiver");
        resumeChar = 8'h5A;
        stopChar = 8'hA5;
        pulse(6'h28);
        check(st, 6'h30, "enable beats resume flag");
        rx(8'hA5, 1'b0);
        exp_rx(9'h102);
        exp_rx(9'h0A5);
        check(st, 6'h32, "programmed stop");
        idle(20);
        exp_tx(8'h5A);
        done("programmed chars");
        end_of_test();
    end
endmodule
